// >>> hdl/uart_pkg.sv
// Constants and types for the serial port with queues and wakeup
// How it works
// RULE1: queues bypassed until software enables them
// RULE2: wakeup on start, frame, match or queue
// RULE3: serial engine runs on its own kernel tick
// RULE4: bit rate reaches 12.5 Mbit/s
// RULE5: hardware clear-to-send and request-to-send handshake
// RULE6: driver enable asserted around each frame
// RULE7: multiprocessor mute and single-wire half duplex
// RULE8: infrared pulse encoder and decoder
// RULE9: LIN break generation and detection
// RULE10: smartcard and synchronous modes when capable
// RULE11: receiver idle timeout raises an interrupt
// RULE12: automatic bit rate from reference character
// RULE13: DMA requests for transmit and receive
// RULE14: low-power rate 9600 from 32.768 kHz; the tick only divides aclk, and there is no 32.768 kHz clock input
// RULE15: 7, 8, 9 data bits; 16-entry queues
package uart_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_BAUD = 5'h04;
	localparam logic [4:0] OFF_STAT = 5'h08;
	localparam logic [4:0] OFF_MASK = 5'h0c;
	localparam logic [4:0] OFF_DATA = 5'h10;
	localparam logic [4:0] OFF_RTO = 5'h14;
	localparam logic [4:0] OFF_MATCH = 5'h18;
	localparam logic [4:0] OFF_LINE = 5'h1c;
	// Control fields
	localparam int C_EN = 0;
	localparam int C_FIFO = 1;
	localparam int C_LEN = 2;
	localparam int C_CTS = 4;
	localparam int C_RTS = 5;
	localparam int C_DE = 6;
	localparam int C_MUTE = 7;
	localparam int C_HD = 8;
	localparam int C_IRDA = 9;
	localparam int C_LIN = 10;
	localparam int C_BRK = 11;
	localparam int C_SYNC = 12;
	localparam int C_SCARD = 13;
	localparam int C_ABR = 14;
	localparam int C_DMAT = 15;
	localparam int C_DMAR = 16;
	localparam int C_WAKE = 17;
	localparam int CTRL_W = 19;
	// Status and mask bits
	localparam int S_RX = 0;
	localparam int S_TXC = 1;
	localparam int S_RTO = 2;
	localparam int S_BRK = 3;
	localparam int S_WAKE = 4;
	localparam int S_ABR = 5;
	localparam int S_FE = 6;
	localparam int S_ORE = 7;
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 19'h00000;
	localparam logic [15:0] BAUD_RST = 16'h0010;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 250_000_000;
	localparam int OVS = 16;
	localparam int MAX_BPS = 12_500_000;
	localparam int MIN_DIV = CLK_HZ / (OVS * MAX_BPS);
	localparam int LSE_HZ = 32768;
	localparam int LP_BPS = 9600;
	localparam int BRK_BITS = 13;
	localparam int IRDA_PULSE = 3;
	localparam int QDEPTH = 16;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic {TX_IDLE, TX_SEND} tx_state_type;
	typedef enum logic [1:0] {
		RX_IDLE, RX_START, RX_DATA, RX_STOP
	} rx_state_type;
endpackage

// >>> hdl/tick_gen.sv
// Oversampling tick divider for the serial engine
`timescale 1ns/1ns
module tick_gen import uart_pkg::*; (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Divisor in clock cycles per tick
	input wire logic [15:0] div,
	// One-cycle tick
	output logic tick
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} tick_state_type;
	tick_state_type s, v;

	// Count to the divisor, zero acts as one
	always_comb begin
		v = s;
		v.tick = 1'b0;
		if (s.cnt + 16'h0001 >= div || div == 16'h0000) begin
			v.cnt = 16'h0000;
			v.tick = 1'b1;
		end else begin
			v.cnt = s.cnt + 16'h0001;
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= v;
		end
	end

	assign tick = s.tick;
endmodule

// >>> hdl/serial_queue.sv
// Data queue that acts as a single buffer while disabled
`timescale 1ns/1ns
module serial_queue import uart_pkg::*; #(
	parameter int W = 9,
	parameter int DEPTH = QDEPTH
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Queue enable, else one entry
	input wire logic en,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	// Fill level
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
		$error("serial_queue depth must be a power of two");
	end
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} queue_state_type;
	queue_state_type s, v;
	logic push, pop;

	// Bypass limits the queue to one entry
	assign in_ready = en ? (s.cnt < (AW+1)'(DEPTH)) : (s.cnt == '0); // RULE1
	assign out_valid = (s.cnt != '0);
	assign out_data = s.mem[s.rp];
	assign level = s.cnt;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointers and count
	always_comb begin
		v = s;
		if (push) begin
			v.mem[s.wp] = in_data;
			v.wp = s.wp + 1'b1;
		end
		if (pop) begin
			v.rp = s.rp + 1'b1;
		end
		if (push && !pop) begin
			v.cnt = s.cnt + 1'b1;
		end else if (pop && !push) begin
			v.cnt = s.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= v;
		end
	end
endmodule

// >>> hdl/serial_port.sv
// Serial transceiver with queues, wakeup and AXI4-Lite registers
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
module serial_port import uart_pkg::*; #(
	parameter bit SYNC_CAPABLE = 1'b1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [4:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [4:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Serial line
	input wire logic rx_i,
	input wire logic tx_i,
	output logic tx_o,
	output logic tx_oe,
	input wire logic cts_n,
	output logic rts_n,
	output logic de,
	output logic sclk,
	// System
	input wire logic stop_mode,
	output logic wake_req,
	output logic irq,
	output logic dma_tx_req,
	output logic dma_rx_req
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [15:0] baud;
		logic [7:0] stat;
		logic [7:0] mask;
		logic [15:0] rto;
		logic [8:0] match;
		logic aw_got, w_got, bvalid, rvalid;
		logic [4:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [1:0] bresp, rresp;
		logic [31:0] rdata;
		tx_state_type tx_st;
		logic [15:0] tx_sh;
		logic [4:0] tx_cnt;
		logic [3:0] tx_ph;
		rx_state_type rx_st;
		logic [8:0] rx_sh;
		logic [3:0] rx_bit, rx_ph;
		logic rx_low, rx_prev;
		logic [19:0] rto_cnt;
		logic rto_arm, abr_on;
		logic [19:0] abr_cnt;
		logic pin, oe, de, sclk, wake;
	} port_state_type;
	port_state_type s, v;

	logic tick, txq_iv, txq_ir, txq_ov, txq_or, rxq_iv, rxq_ir;
	logic rxq_ov, rxq_or;
	logic [8:0] txq_d, rxq_in, rxq_d;
	logic [4:0] txq_lv, rxq_lv;
	logic [CTRL_W-1:0] cmask;

	// Data bits from the length field
	function automatic logic [3:0] nbits(input logic [1:0] len);
		case (len)
			2'b00: nbits = 4'd8;
			2'b01: nbits = 4'd9;
			default: nbits = 4'd7;
		endcase
	endfunction

	// Byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] d, input logic [3:0] b);
		merge = o;
		for (int i = 0; i < 4; i++) begin
			if (b[i]) begin
				merge[i*8 +: 8] = d[i*8 +: 8];
			end
		end
	endfunction

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	// Kernel tick keeps running regardless of software activity
	tick_gen u_tick (.aclk(aclk), .aresetn(aresetn), .div(s.baud),
		.tick(tick)); // RULE3 RULE4 RULE14

	serial_queue #(.W(9), .DEPTH(QDEPTH)) u_txq (.aclk(aclk),
		.aresetn(aresetn), .en(s.ctrl[C_FIFO]), .in_valid(txq_iv),
		.in_ready(txq_ir), .in_data(s.wdata[8:0]),
		.out_valid(txq_ov), .out_ready(txq_or), .out_data(txq_d),
		.level(txq_lv)); // RULE15

	serial_queue #(.W(9), .DEPTH(QDEPTH)) u_rxq (.aclk(aclk),
		.aresetn(aresetn), .en(s.ctrl[C_FIFO]), .in_valid(rxq_iv),
		.in_ready(rxq_ir), .in_data(rxq_in),
		.out_valid(rxq_ov), .out_ready(rxq_or), .out_data(rxq_d),
		.level(rxq_lv)); // RULE15

	// Modes that need a clock pin exist only when capable
	assign cmask = SYNC_CAPABLE ? '1 :
		~((CTRL_W)'(1) << C_SYNC | (CTRL_W)'(1) << C_SCARD); // RULE10

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] ev, clr;
		logic [3:0] nb;
		logic [8:0] d;
		logic hd, rxl, b, hit;
		logic [3:0] wk;
		ev = 8'h00;
		clr = 8'h00;
		nb = nbits(s.ctrl[C_LEN +: 2]);
		d = 9'h000;
		hd = s.ctrl[C_HD] | s.ctrl[C_SCARD];
		rxl = hd ? tx_i : rx_i; // RULE7
		b = 1'b1;
		hit = 1'b0;
		wk = 4'h0;
		v = s;
		v.wake = 1'b0;
		txq_iv = 1'b0;
		txq_or = 1'b0;
		rxq_iv = 1'b0;
		rxq_in = 9'h000;
		rxq_or = 1'b0;
		// Bus: address and data taken in either order
		if (awvalid && awready) begin
			v.aw_got = 1'b1;
			v.awaddr = awaddr;
		end
		if (wvalid && wready) begin
			v.w_got = 1'b1;
			v.wdata = wdata;
			v.wstrb = wstrb;
		end
		if (s.bvalid && bready) begin
			v.bvalid = 1'b0;
		end
		if (s.rvalid && rready) begin
			v.rvalid = 1'b0;
		end
		// Register write once both halves are held
		if (s.aw_got && s.w_got && !s.bvalid) begin
			v.aw_got = 1'b0;
			v.w_got = 1'b0;
			v.bvalid = 1'b1;
			v.bresp = 2'b00;
			if (s.awaddr == OFF_CTRL) begin
				v.ctrl = CTRL_W'(merge(32'(s.ctrl), s.wdata, s.wstrb))
					& cmask;
			end else if (s.awaddr == OFF_BAUD) begin
				v.baud = 16'(merge(32'(s.baud), s.wdata, s.wstrb));
			end else if (s.awaddr == OFF_STAT) begin
				clr = 8'(merge(32'h0, s.wdata, s.wstrb));
			end else if (s.awaddr == OFF_MASK) begin
				v.mask = 8'(merge(32'(s.mask), s.wdata, s.wstrb));
			end else if (s.awaddr == OFF_DATA) begin
				txq_iv = s.wstrb[0];
			end else if (s.awaddr == OFF_RTO) begin
				v.rto = 16'(merge(32'(s.rto), s.wdata, s.wstrb));
			end else if (s.awaddr == OFF_MATCH) begin
				v.match = 9'(merge(32'(s.match), s.wdata, s.wstrb));
			end else if (s.awaddr != OFF_LINE) begin
				v.bresp = 2'b10;
			end
		end
		// Register read; data read pops the receive queue
		if (arvalid && arready) begin
			v.rvalid = 1'b1;
			v.rresp = 2'b00;
			v.rdata = 32'h0;
			if (araddr == OFF_CTRL) begin
				v.rdata = 32'(s.ctrl);
			end else if (araddr == OFF_BAUD) begin
				v.rdata = 32'(s.baud);
			end else if (araddr == OFF_STAT) begin
				v.rdata = 32'(s.stat);
			end else if (araddr == OFF_MASK) begin
				v.rdata = 32'(s.mask);
			end else if (araddr == OFF_DATA) begin
				v.rdata = rxq_ov ? 32'(rxq_d) : 32'h0;
				rxq_or = 1'b1;
			end else if (araddr == OFF_RTO) begin
				v.rdata = 32'(s.rto);
			end else if (araddr == OFF_MATCH) begin
				v.rdata = 32'(s.match);
			end else if (araddr == OFF_LINE) begin
				v.rdata = {20'h0, s.rx_st == RX_IDLE,
					s.tx_st == TX_SEND, rxq_lv, txq_lv};
			end else begin
				v.rresp = 2'b10;
			end
		end
		// Transmitter: a break starts at once, a data frame only while the peer allows
		if (s.tx_st == TX_IDLE) begin
			if (s.ctrl[C_EN] && s.ctrl[C_BRK]) begin
				v.tx_st = TX_SEND; // RULE9
				v.tx_sh = 16'hffff << BRK_BITS; // Low break, then stop
				v.tx_cnt = 5'(BRK_BITS + 1);
				v.tx_ph = 4'h0;
				v.ctrl[C_BRK] = 1'b0;
			end else if (s.ctrl[C_EN] && txq_ov &&
				!(s.ctrl[C_CTS] && cts_n)) begin // RULE5
				txq_or = 1'b1;
				v.tx_st = TX_SEND;
				v.tx_sh = {6'h00, txq_d, 1'b0} |
					(16'hffff << (nb + 4'd1));
				v.tx_cnt = 5'(nb) + 5'd2;
				v.tx_ph = 4'h0;
			end
		end else if (tick) begin
			v.tx_ph = s.tx_ph + 4'h1;
			if (s.tx_ph == 4'hf) begin
				v.tx_sh = {1'b1, s.tx_sh[15:1]};
				v.tx_cnt = s.tx_cnt - 5'd1;
				if (s.tx_cnt == 5'd1) begin
					v.tx_st = TX_IDLE;
					ev[S_TXC] = 1'b1;
				end
			end
		end
		// Line level, infrared zero is a short low pulse
		if (v.tx_st != TX_SEND) begin
			v.pin = 1'b1;
		end else if (s.ctrl[C_IRDA]) begin
			v.pin = v.tx_sh[0] ||
				v.tx_ph >= 4'(IRDA_PULSE); // RULE8
		end else begin
			v.pin = v.tx_sh[0];
		end
		v.oe = !hd || v.tx_st == TX_SEND; // RULE7
		v.de = s.ctrl[C_DE] && v.tx_st == TX_SEND; // RULE6
		// Bit clock in synchronous mode, card clock in smartcard
		if (s.ctrl[C_SYNC]) begin
			v.sclk = v.tx_st == TX_SEND && v.tx_ph[3]; // RULE10
		end else if (s.ctrl[C_SCARD]) begin
			v.sclk = tick ? !s.sclk : s.sclk; // RULE10
		end else begin
			v.sclk = 1'b0;
		end
		// Receiver
		v.rx_prev = rxl;
		case (s.rx_st)
			RX_IDLE: begin
				if (s.ctrl[C_EN] && s.rx_prev && !rxl &&
					!(hd && s.tx_st == TX_SEND)) begin
					v.rx_st = RX_START;
					v.rx_ph = 4'h0;
					wk[0] = 1'b1;
					if (s.ctrl[C_ABR]) begin
						v.abr_on = 1'b1; // RULE12
						v.abr_cnt = 20'h0;
					end
				end
			end
			RX_START: begin
				if (tick) begin
					v.rx_ph = s.rx_ph + 4'h1;
					if (s.rx_ph == 4'h7) begin
						v.rx_st = (s.ctrl[C_IRDA] || !rxl) ?
							RX_DATA : RX_IDLE;
						v.rx_ph = 4'h0;
						v.rx_bit = 4'h0;
						v.rx_low = 1'b0;
					end
				end
			end
			default: begin
				if (tick) begin
					v.rx_ph = s.rx_ph + 4'h1;
					v.rx_low = s.rx_low | !rxl;
					b = s.ctrl[C_IRDA] ? !(s.rx_low | !rxl)
						: rxl; // RULE8
					if (s.rx_ph == 4'hf) begin
						v.rx_low = 1'b0;
						if (s.rx_st == RX_DATA) begin
							v.rx_sh = {b, s.rx_sh[8:1]};
							v.rx_bit = s.rx_bit + 4'h1;
							if (s.rx_bit + 4'h1 == nb) begin
								v.rx_st = RX_STOP;
							end
						end else begin
							v.rx_st = RX_IDLE;
							d = s.rx_sh >> (4'd9 - nb);
							hit = (d == s.match);
							v.rto_cnt = 20'h0;
							v.rto_arm = 1'b1;
							if (!b) begin
								if (d == 9'h000 && s.ctrl[C_LIN])
									ev[S_BRK] = 1'b1; // RULE9
								else
									ev[S_FE] = 1'b1;
							end else begin
								wk[1] = 1'b1;
								wk[2] = hit;
								// Muted until the address matches
								if (s.ctrl[C_MUTE] && hit)
									v.ctrl[C_MUTE] = 1'b0; // RULE7
								if (!s.ctrl[C_MUTE] || hit) begin
									rxq_iv = 1'b1;
									rxq_in = d;
									ev[S_RX] = rxq_ir;
									ev[S_ORE] = !rxq_ir;
								end
							end
						end
					end
				end
			end
		endcase
		// Auto rate: low time of the start bit over oversampling
		if (s.abr_on) begin
			if (!rxl) begin
				v.abr_cnt = s.abr_cnt + 20'h1;
			end else begin
				v.abr_on = 1'b0;
				v.baud = (s.abr_cnt[19:4] == 16'h0) ? 16'h1
					: s.abr_cnt[19:4]; // RULE12
				v.ctrl[C_ABR] = 1'b0;
				ev[S_ABR] = 1'b1;
			end
		end
		// Idle timeout counted in ticks after the last frame
		if (s.rto_arm && s.rx_st == RX_IDLE && tick) begin
			v.rto_cnt = s.rto_cnt + 20'h1;
			if (s.rto != 16'h0 && s.rto_cnt == {s.rto, 4'h0}) begin
				v.rto_arm = 1'b0;
				ev[S_RTO] = 1'b1; // RULE11
			end
		end
		// Wakeup source select while stopped
		// Queue-full source fires on each push taken while 15 entries are held
		wk[3] = s.ctrl[C_FIFO] && rxq_iv && rxq_ir &&
			rxq_lv == 5'(QDEPTH - 1);
		if (stop_mode && wk[s.ctrl[C_WAKE +: 2]]) begin
			v.wake = 1'b1; // RULE2
			ev[S_WAKE] = 1'b1;
		end
		// Sticky status, a new event wins over its clear
		v.stat = (s.stat & ~clr) | ev;
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.ctrl <= CTRL_RST; // RULE1
			s.baud <= BAUD_RST;
			s.pin <= 1'b1;
			s.oe <= 1'b1;
			s.rx_prev <= 1'b1;
		end else begin
			s <= v;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign awready = !s.aw_got && !s.bvalid;
	assign wready = !s.w_got && !s.bvalid;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = !s.rvalid;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign tx_o = s.pin;
	assign tx_oe = s.oe;
	assign de = s.de;
	assign sclk = s.sclk;
	assign rts_n = s.ctrl[C_RTS] && !rxq_ir; // RULE5
	assign wake_req = s.wake;
	assign irq = |(s.stat & s.mask);
	assign dma_tx_req = s.ctrl[C_DMAT] && txq_ir; // RULE13
	assign dma_rx_req = s.ctrl[C_DMAR] && rxq_ov; // RULE13
endmodule

// >>> verification/serial_port_checker.sv
// Port-level checks on the register bus and the line
`timescale 1ns/1ns
module serial_port_checker (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// Line and system
	input wire logic tx_o,
	input wire logic tx_oe,
	input wire logic de,
	input wire logic wake_req,
	input wire logic irq
);
	// ----------------------------------------
	// Sequences and properties
	// ----------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_taken;
		arvalid && arready;
	endsequence
	property p_wr_answer;
		s_wr_taken |-> ##[1:2] bvalid;
	endproperty
	property p_rd_answer;
		s_rd_taken |=> rvalid;
	endproperty
	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	property p_no_aw;
		bvalid |-> !awready && !wready;
	endproperty
	property p_no_ar;
		rvalid |-> !arready;
	endproperty
	// Reset must park the line idle, so it is checked during reset
	property p_reset;
		disable iff (1'b0) !aresetn |=> tx_o && tx_oe && !de && !wake_req
			&& !irq;
	endproperty
	property p_wake_pulse;
		wake_req |=> !wake_req;
	endproperty
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_wr_answer: assert property (p_wr_answer) else $error("no write answer");
	a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	a_no_aw: assert property (p_no_aw) else $error("write taken too early");
	a_no_ar: assert property (p_no_ar) else $error("read taken too early");
	a_reset: assert property (p_reset) else $error("line not idle in reset");
	a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
endmodule
bind serial_port serial_port_checker i_serial_port_checker (.aclk, .aresetn,
	.awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp,
	.arvalid, .arready, .rvalid, .rready, .rdata, .tx_o, .tx_oe, .de,
	.wake_req, .irq);

// >>> verification/line_peer.sv
// Remote serial device model on the line side
`timescale 1ns/1ns
module line_peer #(
	parameter int BIT_CYC = 16
) (
	// Clock
	input wire logic aclk,
	// Line from the port
	input wire logic tx_o,
	input wire logic de,
	input wire logic rts_n,
	// Line to the port
	output logic rx_i,
	output logic cts_n
);
	logic [8:0] got_r = '0; // Last frame seen on tx_o
	logic de_seen = 1'b0; // Driver enable seen mid start bit
	int got_cnt = 0; // Frames seen
	int nbits = 8; // Character length expected
	initial begin
		rx_i = 1'b1;
		cts_n = 1'b0;
	end
	// Receiver: sample each bit in its middle
	always begin
		@(negedge tx_o);
		got_r = '0;
		repeat (BIT_CYC / 2) @(posedge aclk);
		de_seen = de;
		for (int i = 0; i < nbits; i++) begin
			repeat (BIT_CYC) @(posedge aclk);
			got_r[i] = tx_o;
		end
		repeat (BIT_CYC) @(posedge aclk);
		got_cnt++;
	end
	// Send one 8-bit frame, holding off up to 5000 cycles while the port asks us to wait
	task automatic send(input logic [7:0] b);
		int w;
		w = 0;
		while (rts_n === 1'b1 && w < 5000) begin
			@(posedge aclk);
			w++;
		end
		@(posedge aclk);
		rx_i <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			repeat (BIT_CYC) @(posedge aclk);
			rx_i <= (i < 8) ? b[i] : 1'b1;
		end
		repeat (BIT_CYC) @(posedge aclk);
	endtask
endmodule

// >>> verification/serial_port_tb_top.sv
// Self-checking bench for the serial port
`timescale 1ns/1ns
module serial_port_tb_top import uart_pkg::*;;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, stop_mode = 1'b0;
	logic [4:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid, rx_i, tx_o, tx_oe;
	logic cts_n, rts_n, de, sclk, wake_req, irq, dma_tx_req, dma_rx_req;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata, rd;
	int err_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #2 aclk = ~aclk;
	serial_port #(.SYNC_CAPABLE(1'b1)) i_serial_port (.aclk, .aresetn,
		.awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp, .rx_i, .tx_i(tx_o), .tx_o, .tx_oe,
		.cts_n, .rts_n, .de, .sclk, .stop_mode, .wake_req, .irq,
		.dma_tx_req, .dma_rx_req);
	line_peer #(.BIT_CYC(16)) i_line_peer (.aclk, .tx_o, .de, .rts_n,
		.rx_i, .cts_n);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Write: release each channel when taken, then take the answer
	task automatic wr(input logic [4:0] a, input logic [31:0] d,
		output logic [1:0] r);
		bit done;
		done = 1'b0;
		r = 'x;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// Only the bench timeout ends this wait
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bready && bvalid) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end else if (bvalid)
				bready <= 1'b1;
		end
	endtask
	task automatic rdr(input logic [4:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit done;
		done = 1'b0;
		d = 'x;
		r = 'x;
		araddr <= a;
		arvalid <= 1'b1;
		// Only the bench timeout ends this wait
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rready && rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end else if (rvalid)
				rready <= 1'b1;
		end
	endtask
	task automatic wreg(input logic [4:0] a, input logic [31:0] d);
		wr(a, d, rs);
		chk(rs, 2'b00);
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] e,
		input logic [31:0] m);
		rdr(a, rd, rs);
		chk(rs, 2'b00);
		chk(rd & m, e);
	endtask
	task automatic wait_frame(input int c);
		int n;
		n = 0;
		while (i_line_peer.got_cnt <= c && n < 2000) begin
			@(posedge aclk);
			n++;
		end
		chk(n < 2000, 1'b1);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rchk(OFF_CTRL, 32'h0, 32'hffffffff);
		rchk(OFF_BAUD, 32'h10, 32'hffff);
		wr(5'h02, 32'h1, rs);
		chk(rs, 2'b10);
	endtask
	// Held-off send, then 8-bit and 7-bit characters with driver enable
	task automatic t_tx;
		int c;
		i_line_peer.cts_n <= 1'b1;
		wreg(OFF_BAUD, 32'h1);
		wreg(OFF_CTRL, 32'h51);
		wreg(OFF_DATA, 32'h55);
		repeat (100) @(posedge aclk);
		chk(tx_o, 1'b1);
		c = i_line_peer.got_cnt;
		i_line_peer.cts_n <= 1'b0;
		wait_frame(c);
		chk(i_line_peer.got_r, 9'h055);
		chk(i_line_peer.de_seen, 1'b1);
		i_line_peer.nbits = 7;
		wreg(OFF_CTRL, 32'h59);
		wreg(OFF_DATA, 32'h1d5);
		wait_frame(c + 1);
		chk(i_line_peer.got_r, 9'h055);
		i_line_peer.nbits = 8;
	endtask
	// Receive, masked and unmasked interrupt, idle timeout, clear
	task automatic t_rx;
		wreg(OFF_CTRL, 32'h1);
		wreg(OFF_RTO, 32'h2);
		i_line_peer.send(8'ha3);
		chk(irq, 1'b0);
		wreg(OFF_MASK, 32'h1);
		chk(irq, 1'b1);
		rchk(OFF_DATA, 32'ha3, 32'h1ff);
		repeat (60) @(posedge aclk);
		rchk(OFF_STAT, 32'h5, 32'h5);
		wreg(OFF_STAT, 32'hff);
		rchk(OFF_STAT, 32'h0, 32'h1);
		chk(irq, 1'b0);
	endtask
	// One-entry holder overruns; the enabled queue takes 16
	task automatic t_queue;
		i_line_peer.send(8'h11);
		i_line_peer.send(8'h22);
		rchk(OFF_STAT, 32'h80, 32'h80);
		rchk(OFF_DATA, 32'h11, 32'h1ff);
		wreg(OFF_CTRL, 32'h18003);
		wreg(OFF_STAT, 32'hff);
		chk(dma_rx_req, 1'b0);
		chk(dma_tx_req, 1'b1);
		for (int i = 0; i < 16; i++)
			i_line_peer.send(i[7:0]);
		chk(dma_rx_req, 1'b1);
		rchk(OFF_LINE, 32'h200, 32'h3e0);
		rchk(OFF_STAT, 32'h0, 32'h80);
		for (int i = 0; i < 16; i++)
			rchk(OFF_DATA, 32'(i), 32'h1ff);
		chk(dma_rx_req, 1'b0);
	endtask
	// Count wake pulses over one incoming frame in stop state
	task automatic wake_try(input logic [31:0] c, input logic [7:0] b,
		input int e);
		int n;
		n = 0;
		wreg(OFF_CTRL, c);
		fork
			i_line_peer.send(b);
			repeat (200) begin
				@(posedge aclk);
				if (wake_req === 1'b1)
					n++;
			end
		join
		chk(n, e);
		rdr(OFF_DATA, rd, rs);
	endtask
	task automatic t_wake;
		stop_mode <= 1'b1;
		wreg(OFF_MATCH, 32'h5a);
		wake_try(32'h00001, 8'h5a, 1);
		wake_try(32'h20001, 8'h5a, 1);
		wake_try(32'h40001, 8'h11, 0);
		wake_try(32'h40001, 8'h5a, 1);
		stop_mode <= 1'b0;
	endtask
	// Half duplex with bit clock, then a break on the transmit pin
	task automatic t_modes;
		int n, k;
		n = 0;
		k = 0;
		wreg(OFF_CTRL, 32'h1101);
		chk(tx_oe, 1'b0);
		fork
			wreg(OFF_DATA, 32'h3c);
			repeat (200) begin
				@(posedge aclk);
				n += tx_oe;
				k += sclk;
			end
		join
		chk(n, 10 * OVS);
		chk(k, 5 * OVS);
		chk(i_line_peer.got_r, 9'h03c);
		n = 0;
		fork
			wreg(OFF_CTRL, 32'h801);
			repeat (300) begin
				@(posedge aclk);
				n += !tx_o;
			end
		join
		chk(n, BRK_BITS * OVS);
		chk(i_line_peer.got_r, 9'h000);
	endtask
	// ----------------------------------------
	// Main sequence and timeout
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_tx();
		t_rx();
		t_queue();
		t_wake();
		t_modes();
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(OFF_CTRL, 32'h0, 32'hffffffff);
		complete_run();
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			$display("ERROR %0t timeout", $time);
			complete_run();
		end
	end
endmodule
